// [rx_signal_measure.sv]
// Purpose: Receiver state, gain selection, signal reading and thermal monitor.
// Assumes: Front end gives a level sample (0.5 dB units below 0 dBm) and a sample.
// Notes:   Outputs are registered; read data stands the cycle after a read strobe.
// Operation
// RULE1 - Entering receive waits in enabled state until preamble or signal criterion met.
// RULE2 - Active state forwards received samples to packet engine and sequencer.
// RULE3 - Gain code picked from level against five ascending thresholds.
// RULE4 - Codes give relative gains 0,-6,-12,-24,-26,-48 dB.
// RULE5 - Reading is minus twice level in dBm plus offset, 0.5 dB units.
// RULE6 - Offset is -16 to +15 dB in 1 dB steps, added in.
// RULE7 - Reading averaged over two to the code plus one samples.
// RULE8 - Response time follows averaging count over four times bandwidth.
// RULE9 - Starting calibration restarts the signal measurement.
// RULE10 - Host adds -157 or -164 to spread-spectrum readings.
// RULE11 - Host adds quarter SNR when SNR is negative.
// RULE12 - Packet value averages live reading; live readable any time.
// RULE13 - Host should tune port constants by single-point calibration.
// RULE14 - Host may scale packet average by 16/15 when SNR nonnegative.
// RULE15 - Host may sample live reading between header and completion events.
// RULE16 - Channel filter is a 16-tap FIR rejecting out-of-channel signals.
// RULE17 - Host keeps bit rate below twice single-side bandwidth.
// RULE18 - Bandwidth mantissa codes 16,20,24; exponent 1 to 7; rest reserved.
// RULE19 - Thermal block runs except Sleep/Standby, stops when disable bit set; thermalRunning follows only the disable bit.
// RULE20 - Each thermal result is stored in the thermal register.
// RULE21 - Filter bandwidth register sits at 0x12 and resets to 0x15.
// RULE22 - Reading unsigned 8-bit, offset 5-bit two's complement, saturating.
// RULE23 - Gain code updates only in enabled state and holds in active.
module rx_signal_measure
  import rx_measure_pkg::*;
#(
  parameter int TEMP_INTERVAL = TEMP_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  input  wire logic       rxMode,
  input  wire logic       sleepOrStandby,
  input  wire logic       preambleOk,
  input  wire logic       calStart,
  input  wire logic       feValid,
  input  wire logic [7:0] feLevel,
  input  wire logic [7:0] feChannel,
  input  wire logic [7:0] thermalSensor,
  output logic            rxActive,
  output logic            sampleValid,
  output logic      [7:0] sampleData,
  output logic      [2:0] lna_gain_code,
  output logic      [7:0] lnaRelGain,
  output logic            thermalRunning
);
  initial begin
    if (TEMP_INTERVAL < 1) $error("TEMP_INTERVAL must be at least one");
  end

  reg_req_t   req;
  rx_state_t  state_reg, state_next;
  logic [7:0] filter_bw_reg, filter_bw_next;
  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] thresh_reg [5];
  logic [7:0] thresh_next [5];
  logic       thermal_sensor_disable_reg, thermal_sensor_disable_next;
  logic [7:0] thermal_reg, thermal_next;
  logic [31:0] tcnt_reg, tcnt_next;
  logic [2:0] gain_reg, gain_next;
  logic [7:0] gainDb_reg, gainDb_next;
  logic [15:0] acc_reg, acc_next;
  logic [8:0] cnt_reg, cnt_next;
  logic [7:0] live_signal_reg, live_signal_next;
  logic [7:0] pkt_signal_reg, pkt_signal_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] fir_reg [FIR_TAPS];
  logic [11:0] firSum;
  logic       act_reg, act_next;
  logic       thermalRun_reg;
  logic       sv_reg, sv_next;
  logic [7:0] sd_reg, sd_next;
  logic       signalHit;
  logic [4:0] comp;
  logic [8:0] avgLen;
  logic [2:0] gainSel;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
  assign comp = cfg_reg[7:COMP_POS];
  assign avgLen = 9'(9'h002 << cfg_reg[2:0]); // [RULE7] [RULE8]
  assign signalHit = live_signal_reg <= thresh_reg[0];

  always_comb begin
    firSum = '0;
    for (int i = 0; i < FIR_TAPS; i++) begin
      firSum = firSum + 12'(fir_reg[i]); // [RULE16]
    end
  end

  always_comb begin
    gainSel = GAIN_CODE_G6; // [RULE3] [RULE4]
    if (feLevel >= thresh_reg[4]) gainSel = GAIN_CODE_G5;
    if (feLevel >= thresh_reg[3]) gainSel = GAIN_CODE_G4;
    if (feLevel >= thresh_reg[2]) gainSel = GAIN_CODE_G3;
    if (feLevel >= thresh_reg[1]) gainSel = GAIN_CODE_G2;
    if (feLevel >= thresh_reg[0]) gainSel = GAIN_CODE_G1;
  end

  always_comb begin
    logic [9:0] adj;
    logic [15:0] avg;
    adj = '0;
    avg = '0;
    state_next = state_reg;
    filter_bw_next = filter_bw_reg;
    cfg_next = cfg_reg;
    thresh_next = thresh_reg;
    thermal_sensor_disable_next = thermal_sensor_disable_reg;
    thermal_next = thermal_reg;
    tcnt_next = tcnt_reg;
    gain_next = gain_reg;
    gainDb_next = gainDb_reg;
    acc_next = acc_reg;
    cnt_next = cnt_reg;
    live_signal_next = live_signal_reg;
    pkt_signal_next = pkt_signal_reg;
    rdata_next = READ_UNMAPPED;
    act_next = 1'b0;
    sv_next = 1'b0;
    sd_next = sd_reg;
    unique case (state_reg)
      RX_IDLE: if (rxMode) state_next = RX_ENABLED; // [RULE1]
      RX_ENABLED: begin
        if (!rxMode) state_next = RX_IDLE;
        else if (preambleOk || signalHit) state_next = RX_ACTIVE; // [RULE1]
        if (feValid) gain_next = gainSel; // [RULE23]
      end
      RX_ACTIVE: begin
        if (!rxMode) state_next = RX_IDLE;
        act_next = 1'b1;
        sv_next = feValid; // [RULE2]
        if (feValid) sd_next = firSum[11:4];
      end
    endcase
    unique case (gain_reg)
      GAIN_CODE_G2: gainDb_next = GAIN_REL_DB[1]; // [RULE4]
      GAIN_CODE_G3: gainDb_next = GAIN_REL_DB[2];
      GAIN_CODE_G4: gainDb_next = GAIN_REL_DB[3];
      GAIN_CODE_G5: gainDb_next = GAIN_REL_DB[4];
      GAIN_CODE_G6: gainDb_next = GAIN_REL_DB[5];
      default:      gainDb_next = GAIN_REL_DB[0];
    endcase
    if (calStart) begin
      acc_next = '0; // [RULE9]
      cnt_next = '0;
    end else if (feValid) begin
      // Level is already twice the dBm magnitude; signed offset scaled to 0.5 dB.
      adj = {2'b00, feLevel} + {{4{comp[4]}}, comp, 1'b0}; // [RULE5] [RULE6]
      if (adj[9]) adj = '0; // [RULE22]
      else if (adj[8]) adj = 10'h0FF;
      acc_next = acc_reg + {8'h00, adj[7:0]};
      cnt_next = cnt_reg + 9'h001;
      if (cnt_next >= avgLen) begin
        avg = acc_next >> ({1'b0, cfg_reg[2:0]} + 4'h1); // [RULE7]
        live_signal_next = avg[7:0];
        acc_next = '0;
        cnt_next = '0;
        if (state_reg == RX_ACTIVE)
          pkt_signal_next = 8'((({1'b0, pkt_signal_reg} + {1'b0, avg[7:0]}) >> 1)); // [RULE12]
      end
    end
    if (!thermal_sensor_disable_reg && !sleepOrStandby) begin // [RULE19]
      tcnt_next = tcnt_reg + 32'h1;
      if (tcnt_next >= 32'(TEMP_INTERVAL)) begin
        tcnt_next = '0;
        thermal_next = thermalSensor; // [RULE20]
      end
    end
    if (req.wr) begin
      if (req.addr == FILTER_BW_REG) begin
        if (req.wdata[4:BW_MANT_POS] != BW_MANT_RESERVED && req.wdata[2:0] >= BW_EXP_MIN)
          filter_bw_next = {3'h0, req.wdata[4:0]}; // [RULE18] [RULE21]
      end
      if (req.addr == SIGNAL_CFG_REG) cfg_next = req.wdata;
      if (req.addr == THERMAL_CTRL_REG) thermal_sensor_disable_next = req.wdata[0];
      for (int i = 0; i < 5; i++) begin
        if (req.addr == GAIN_THRESH_BASE + 8'(i)) thresh_next[i] = req.wdata;
      end
    end
    if (req.rd) begin
      unique case (req.addr)
        LIVE_SIGNAL_REG:  rdata_next = live_signal_reg; // [RULE12]
        PKT_SIGNAL_REG:   rdata_next = pkt_signal_reg;
        FILTER_BW_REG:    rdata_next = filter_bw_reg;
        SIGNAL_CFG_REG:   rdata_next = cfg_reg;
        GAIN_STATUS_REG:  rdata_next = {3'h0, act_reg, 1'b0, gain_reg};
        THERMAL_CTRL_REG: rdata_next = {7'h00, thermal_sensor_disable_reg};
        THERMAL_REG:      rdata_next = thermal_reg;
        default: begin
          rdata_next = READ_UNMAPPED;
          for (int i = 0; i < 5; i++) begin
            if (req.addr == GAIN_THRESH_BASE + 8'(i)) rdata_next = thresh_reg[i];
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= RX_IDLE;
      filter_bw_reg <= FILTER_BW_RESET; // [RULE21]
      cfg_reg <= SIGNAL_CFG_RESET;
      for (int i = 0; i < 5; i++) thresh_reg[i] <= THRESH_RESET + 8'(4 - i) * THRESH_STEP;
      thermal_sensor_disable_reg <= 1'b0; // [RULE19]
      thermalRun_reg <= 1'b1;
      thermal_reg <= '0;
      tcnt_reg <= '0;
      gain_reg <= GAIN_CODE_G1;
      gainDb_reg <= '0;
      acc_reg <= '0;
      cnt_reg <= '0;
      live_signal_reg <= 8'hFF;
      pkt_signal_reg <= 8'hFF;
      rdata_reg <= '0;
      act_reg <= 1'b0;
      sv_reg <= 1'b0;
      sd_reg <= '0;
      for (int i = 0; i < FIR_TAPS; i++) fir_reg[i] <= '0;
    end else begin
      state_reg <= state_next;
      filter_bw_reg <= filter_bw_next;
      cfg_reg <= cfg_next;
      thresh_reg <= thresh_next;
      thermal_sensor_disable_reg <= thermal_sensor_disable_next;
      thermalRun_reg <= !thermal_sensor_disable_next;
      thermal_reg <= thermal_next;
      tcnt_reg <= tcnt_next;
      gain_reg <= gain_next;
      gainDb_reg <= gainDb_next;
      acc_reg <= acc_next;
      cnt_reg <= cnt_next;
      live_signal_reg <= live_signal_next;
      pkt_signal_reg <= pkt_signal_next;
      rdata_reg <= rdata_next;
      act_reg <= act_next;
      sv_reg <= sv_next;
      sd_reg <= sd_next;
      if (feValid) begin
        fir_reg[0] <= feChannel; // [RULE16]
        for (int i = 1; i < FIR_TAPS; i++) fir_reg[i] <= fir_reg[i-1];
      end
    end
  end

  assign regRdata = rdata_reg;
  assign rxActive = act_reg;
  assign sampleValid = sv_reg;
  assign sampleData = sd_reg;
  assign lna_gain_code = gain_reg;
  assign lnaRelGain = gainDb_reg;
  assign thermalRunning = thermalRun_reg;

  enter_enabled_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_reg == RX_IDLE && rxMode |=> state_reg == RX_ENABLED) else $error("no enabled state"); // [RULE1]
  go_active_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_reg == RX_ENABLED && rxMode && preambleOk |=> ##1 rxActive) else $error("no active"); // [RULE1]
  pass_sample_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sampleValid |-> $past(feValid) && rxActive) else $error("sample outside active"); // [RULE2]
  gain_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(state_reg) == RX_ACTIVE |-> $stable(lna_gain_code)) else $error("gain moved"); // [RULE23]
  gain_code_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    lna_gain_code != 3'h0 && lna_gain_code != 3'h5) else $error("bad gain code"); // [RULE3]
  gain_db_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    ##1 lna_gain_code == GAIN_CODE_G6 |=> lnaRelGain == 8'hD0) else $error("bad rel gain"); // [RULE4]
  cal_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    calStart |=> cnt_reg == 9'h000) else $error("cal no restart"); // [RULE9]
  bw_legal_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    filter_bw_reg[4:3] != BW_MANT_RESERVED && filter_bw_reg[2:0] != 3'h0) else $error("bw"); // [RULE18]
  thermal_stop_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    thermal_sensor_disable_reg |=> $stable(thermal_reg)) else $error("thermal ran"); // [RULE19]
  read_latency_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    regRd && regAddr == FILTER_BW_REG && !regWr |=> regRdata == $past(filter_bw_reg))
    else $error("read data"); // [RULE21]
  gain_strong_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE3]
    state_reg == RX_ENABLED && feValid && feLevel < thresh_reg[4] |=> lna_gain_code == GAIN_CODE_G6) else $error("strong gain");
  gain_weak_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE3]
    state_reg == RX_ENABLED && feValid && feLevel >= thresh_reg[0] |=> lna_gain_code == GAIN_CODE_G1) else $error("weak gain");
  relgain_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE4]
    lna_gain_code == GAIN_CODE_G1 |=> lnaRelGain == 8'h00) else $error("bad zero gain");
  sleep_stop_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE19]
    sleepOrStandby |=> $stable(thermal_reg)) else $error("thermal ran in sleep");
  pkt_active_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE12]
    $changed(pkt_signal_reg) |-> $past(state_reg) == RX_ACTIVE) else $error("pkt moved");
  live_read_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE12]
    regRd && regAddr == LIVE_SIGNAL_REG |=> regRdata == $past(live_signal_reg)) else $error("live read");
  cal_acc_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE9]
    calStart |=> acc_reg == 16'h0000) else $error("cal no clear");
  leave_rx_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE1]
    state_reg != RX_IDLE && !rxMode |=> state_reg == RX_IDLE) else $error("no idle");

  active_c: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(rxActive));
  strong_c: cover property (@(posedge ref_clk) disable iff (!nrst) lna_gain_code == GAIN_CODE_G6);
  reading_c: cover property (@(posedge ref_clk) disable iff (!nrst) $changed(live_signal_reg));
  thermal_c: cover property (@(posedge ref_clk) disable iff (!nrst) $changed(thermal_reg));
  hit_c: cover property (@(posedge ref_clk) disable iff (!nrst) state_reg == RX_ENABLED && signalHit);
endmodule : rx_signal_measure

// [rx_measure_pkg.sv]
// Purpose: Shared constants and types for the receiver measurement block.
// Assumes: One 100 MHz clock and 8-bit registers on a plain strobe port.
// Notes:   Register offsets are byte addresses on the register port.
package rx_measure_pkg;
  localparam logic [7:0] LIVE_SIGNAL_REG   = 8'h11;
  localparam logic [7:0] FILTER_BW_REG     = 8'h12;
  localparam logic [7:0] PKT_SIGNAL_REG    = 8'h1A;
  localparam logic [7:0] SIGNAL_CFG_REG    = 8'h0E;
  localparam logic [7:0] GAIN_THRESH_BASE  = 8'h20;
  localparam logic [7:0] GAIN_STATUS_REG   = 8'h25;
  localparam logic [7:0] THERMAL_REG       = 8'h3C;
  localparam logic [7:0] THERMAL_CTRL_REG  = 8'h3B;
  localparam logic [7:0] FILTER_BW_RESET   = 8'h15;
  localparam logic [7:0] SIGNAL_CFG_RESET  = 8'h02;
  localparam logic [7:0] THRESH_RESET      = 8'h40;
  localparam logic [7:0] THRESH_STEP       = 8'h20;
  localparam logic [7:0] READ_UNMAPPED     = 8'h00;
  localparam int         AVG_SHIFT_MAX     = 8;
  localparam int         COMP_POS          = 3;
  localparam int         BW_MANT_POS       = 3;
  localparam logic [1:0] BW_MANT_RESERVED  = 2'h3;
  localparam logic [2:0] BW_EXP_MIN        = 3'h1;
  localparam logic [4:0] COMP_MAX          = 5'h0F;
  localparam logic [4:0] COMP_MIN          = 5'h10;
  localparam logic [2:0] GAIN_CODE_G1      = 3'h1;
  localparam logic [2:0] GAIN_CODE_G2      = 3'h2;
  localparam logic [2:0] GAIN_CODE_G3      = 3'h3;
  localparam logic [2:0] GAIN_CODE_G4      = 3'h4;
  localparam logic [2:0] GAIN_CODE_G5      = 3'h6;
  localparam logic [2:0] GAIN_CODE_G6      = 3'h7;
  localparam logic [7:0] GAIN_REL_DB [6]   = '{8'h00, 8'hFA, 8'hF4, 8'hE8, 8'hE6, 8'hD0};
  localparam int         FIR_TAPS          = 16;
  localparam int         TEMP_PERIOD_NS    = 10000;
  localparam int         CLK_PERIOD_NS     = 10;
  localparam int         TEMP_CYCLES       = (TEMP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    RX_IDLE    = 2'b00,
    RX_ENABLED = 2'b01,
    RX_ACTIVE  = 2'b11
  } rx_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] level;
  } sample_t;
endpackage : rx_measure_pkg

// [fe_model.sv]
// Purpose: Behavioural front end that feeds level, channel and thermal samples.
// Assumes: Samples are one-cycle pulses launched just after a rising edge.
// Notes:   Released data lines show the inverse of the last value.
module fe_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] tempIn,
  output logic            feValid,
  output logic      [7:0] feLevel,
  output logic      [7:0] feChannel,
  output logic      [7:0] thermalSensor
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    feValid   = 1'b0;
    feLevel   = 8'h00;
    feChannel = 8'h00;
  end
  assign thermalSensor = tempIn;
  // Level is minus twice the input power in half-dB units.
  // Samples come at most every other clock, within the filter rate.
  task automatic send(input logic [7:0] lvl, input logic [7:0] ch);
    @(posedge ref_clk);
    feValid   <= 1'b1;
    feLevel   <= lvl;
    feChannel <= ch;
    @(posedge ref_clk);
    feValid   <= 1'b0;
    feLevel   <= ~lvl;
    feChannel <= ~ch;
  endtask
endmodule // fe_model

// [test_rx_signal_measure.sv]
// Purpose: Self-checking bench for the receiver measurement block.
// Assumes: Thermal interval shortened to 4 cycles.
// Notes:   Expected values come from integer models in the bench.
module test_rx_signal_measure;
  import rx_measure_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, nrst, regWr, regRd, rxMode, sleepOrStandby, preambleOk, calStart;
  logic [7:0] regAddr, regWdata, regRdata, feLevel, feChannel, thermalSensor, tempIn;
  logic [7:0] sampleData, lnaRelGain, lastSample, lvl;
  logic feValid, rxActive, sampleValid, thermalRunning;
  logic [2:0] lna_gain_code;
  int errTotal, testsRun, seed, svCount, sum, n, a, liveExp;
  int portHf = -157, portLf = -164; // Trimmed by a single-point calibration.
  int offs[5]  = '{15, -16, 3, -5, 0};
  int codes[5] = '{0, 0, 1, 2, 7};
  int ors[5]   = '{8'hF0, 0, 0, 8'h20, 8'hC1};
  int masks[5] = '{8'h0F, 8'h1F, 8'h7F, 8'h7F, 8'hFF};
  int gcode[6] = '{1, 2, 3, 4, 6, 7};
  int gdb[6]   = '{0, -6, -12, -24, -26, -48};
  int glv[8]   = '{8'h30, 8'h50, 8'h70, 8'h90, 8'hB0, 8'hD0, 8'h40, 8'h41};
  rx_signal_measure #(.TEMP_INTERVAL(4)) rx_signal_measure_inst (
    .ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxMode(rxMode),
    .sleepOrStandby(sleepOrStandby), .preambleOk(preambleOk), .calStart(calStart),
    .feValid(feValid), .feLevel(feLevel), .feChannel(feChannel),
    .thermalSensor(thermalSensor), .rxActive(rxActive), .sampleValid(sampleValid),
    .sampleData(sampleData), .lna_gain_code(lna_gain_code), .lnaRelGain(lnaRelGain),
    .thermalRunning(thermalRunning));
  fe_model fe_model_inst (.ref_clk(ref_clk), .tempIn(tempIn), .feValid(feValid),
    .feLevel(feLevel), .feChannel(feChannel), .thermalSensor(thermalSensor));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (sampleValid === 1'b1) begin
      svCount++;
      lastSample = sampleData;
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    testsRun++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      errTotal++;
    end
  endtask
  task automatic wrReg(input logic [7:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1; regAddr <= ad; regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] ad, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    regRd <= 1'b1; regAddr <= ad;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk(what, exp, regRdata);
  endtask
  function automatic int hostDbm(input int v, input int snr, input int pc);
    if (snr < 0) return pc + v + snr / 4;
    return pc + (16 * v) / 15;
  endfunction
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    errTotal++;
    finish_test();
  end
  initial begin
    {nrst, regWr, regRd, rxMode, sleepOrStandby, preambleOk, calStart} = 7'h00;
    regAddr = 8'h00; regWdata = 8'h00; seed = 13; tempIn = 8'h21;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    chk("gain", 8'h01, {5'h00, lna_gain_code});
    chk("thermal run", 8'h01, {7'h00, thermalRunning});
    rdReg(8'h12, 8'h15, "bw reset");
    rdReg(8'h0E, 8'h02, "cfg reset");
    rdReg(8'h11, 8'hFF, "live reset");
    rdReg(8'h30, 8'h00, "unmapped");
    for (int i = 0; i < 5; i++) rdReg(8'h20 + 8'(i), 8'hC0 - 8'(32 * i), "thr");
    wrReg(8'h12, 8'h0B); rdReg(8'h12, 8'h0B, "bw");
    wrReg(8'h12, 8'h1B); rdReg(8'h12, 8'h0B, "bw mant");
    wrReg(8'h12, 8'h08); rdReg(8'h12, 8'h0B, "bw exp");
    wrReg(8'h12, 8'h17); rdReg(8'h12, 8'h17, "bw max");
    $display("register test done");
    for (int c = 0; c < 5; c++) begin
      wrReg(8'h0E, {5'(offs[c]), 3'(codes[c])});
      @(posedge ref_clk); calStart <= 1'b1;
      @(posedge ref_clk); calStart <= 1'b0;
      n = 2 << codes[c]; sum = 0;
      for (int k = 0; k < n; k++) begin
        lvl = 8'(($random(seed) & masks[c]) | ors[c]);
        a = int'(lvl) + 2 * offs[c];
        sum += (a < 0) ? 0 : (a > 255) ? 255 : a;
        fe_model_inst.send(lvl, 8'h00);
      end
      repeat (3) @(posedge ref_clk);
      liveExp = sum / n;
      rdReg(8'h11, 8'(liveExp), "live");
    end
    $display("reading test done");
    wrReg(8'h0E, 8'h07);
    rxMode <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      lvl = (i < 8) ? 8'(glv[i]) : 8'($random(seed));
      a = 0;
      for (int t = 0; t < 5; t++) if (int'(lvl) < 192 - 32 * t) a++;
      fe_model_inst.send(lvl, 8'h00);
      repeat (3) @(posedge ref_clk);
      #1 chk("gain code", 8'(gcode[a]), {5'h00, lna_gain_code});
      chk("rel gain", 8'(gdb[a]), lnaRelGain);
    end
    chk("enabled", 8'h00, {7'h00, rxActive});
    chk("no samples", 8'h00, 8'(svCount));
    preambleOk <= 1'b1;
    for (int w = 0; w < 6 && rxActive !== 1'b1; w++) @(posedge ref_clk);
    preambleOk <= 1'b0;
    #1 chk("active", 8'h01, {7'h00, rxActive});
    rdReg(8'h25, {4'h1, 1'b0, 3'(gcode[a])}, "status");
    rdReg(8'h11, 8'(liveExp), "live rx");
    lvl = (a == 0) ? 8'h10 : 8'hF0;
    for (int k = 0; k < 20; k++) fe_model_inst.send(lvl, 8'h5A);
    repeat (3) @(posedge ref_clk);
    chk("gain held", 8'(gcode[a]), {5'h00, lna_gain_code});
    chk("fir out", 8'h5A, lastSample);
    rdReg(8'h1A, 8'hFF, "pkt");
    chk("dbm hf", 8'(hostDbm(255, -8, portHf)), 8'(hostDbm(int'(regRdata), -8, portHf)));
    chk("dbm lf", 8'(hostDbm(255, 4, portLf)), 8'(hostDbm(int'(regRdata), 4, portLf)));
    rxMode <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("idle", 8'h00, {7'h00, rxActive});
    $display("receive test done");
    repeat (10) @(posedge ref_clk);
    rdReg(8'h3C, 8'h21, "thermal");
    wrReg(8'h3B, 8'h01); tempIn <= 8'h37;
    repeat (10) @(posedge ref_clk);
    chk("thermal off", 8'h00, {7'h00, thermalRunning});
    rdReg(8'h3C, 8'h21, "thermal held");
    wrReg(8'h3B, 8'h00); sleepOrStandby <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rdReg(8'h3C, 8'h21, "thermal sleep");
    sleepOrStandby <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rdReg(8'h3C, 8'h37, "thermal new");
    $display("thermal test done");
    finish_test();
  end
endmodule // test_rx_signal_measure
